// ==== rtl/pin_mux_pkg.sv ====
package pin_mux_pkg;

  // Register bus geometry.
  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 32;
  localparam int          PORT_W = 8;

  // Register byte offsets.
  localparam logic [7:0]  OFF_P1_LATCH   = 8'h00;
  localparam logic [7:0]  OFF_P1_DIR     = 8'h04;
  localparam logic [7:0]  OFF_P1_FSEL    = 8'h08;
  localparam logic [7:0]  OFF_P1_PINS    = 8'h0c;
  localparam logic [7:0]  OFF_P2_PULL    = 8'h10;
  localparam logic [7:0]  OFF_P2_PINS    = 8'h14;
  localparam logic [7:0]  OFF_P3_LATCH   = 8'h18;
  localparam logic [7:0]  OFF_P3_DIR     = 8'h1c;
  localparam logic [7:0]  OFF_P3_FSEL    = 8'h20;
  localparam logic [7:0]  OFF_P3_PULL    = 8'h24;
  localparam logic [7:0]  OFF_P3_OD      = 8'h28;
  localparam logic [7:0]  OFF_P3_PINS    = 8'h2c;
  localparam logic [7:0]  OFF_P4_LATCH   = 8'h30;
  localparam logic [7:0]  OFF_P4_DIR     = 8'h34;
  localparam logic [7:0]  OFF_P4_PULL    = 8'h38;
  localparam logic [7:0]  OFF_P4_PINS    = 8'h3c;
  localparam logic [7:0]  OFF_MEMX_MODE  = 8'h40;
  localparam logic [7:0]  OFF_CSI1_MODE  = 8'h44;
  localparam logic [7:0]  OFF_IRQ_CFG_A  = 8'h48;
  localparam logic [7:0]  OFF_IRQ_CFG_B  = 8'h4c;

  // Reset values and writable masks; a direction bit of 1 means input.
  localparam logic [7:0]  DIR_RESET      = 8'hff;
  localparam logic [7:0]  ZERO_RESET     = 8'h00;
  localparam logic [7:0]  P1_FSEL_MASK   = 8'h1c;
  localparam logic [7:0]  P2_PULL_MASK   = 8'hfc;
  localparam logic [7:0]  P3_OD_MASK     = 8'h0c;

  // Field positions.
  localparam int          MEMX_EN_BIT    = 0;
  localparam int          CSI1_CLKOUT_BIT = 0;
  localparam int          NMI_RISE_BIT   = 0;
  localparam int          EDGE_RISE      = 0;
  localparam int          EDGE_FALL      = 1;
  localparam int          IRQ_N          = 6;
  localparam int          IRQ_PER_CFG    = 3;
  localparam int          P1_SCK_BIT     = 2;
  localparam int          P1_SIN_BIT     = 3;
  localparam int          P1_SOUT_BIT    = 4;
  localparam int          P2_NMI_BIT     = 0;
  localparam int          P2_IRQ_BASE    = 1;
  localparam int          P2_SERIAL1_CLOCK_BIT    = 5;
  localparam int          P2_SI0_BIT     = 7;
  localparam int          P3_RX_BIT      = 0;
  localparam int          P3_TX_BIT      = 1;
  localparam int          P3_SERIAL0_CLOCK_BIT    = 2;
  localparam int          P3_SO0_BIT     = 3;
  localparam int          P3_TIMER_BASE  = 4;

  // Bus answers.
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // Signals that peripherals hand to the pads.
  typedef struct packed {
    logic       serial2_clock_out;
    logic       serial2_clock_oe;
    logic       serial2_data_out;
    logic       serial1_clock_out;
    logic       serial1_data_out;
    logic       serial0_clock_out;
    logic       serial0_clock_oe;
    logic       serial0_data_out;
    logic [3:0] timer_outputs;
    logic [7:0] ad_out;
    logic       ad_oe;
  } periph_drive_s;

  // Synchronised pin levels and events handed to peripherals.
  typedef struct packed {
    logic       uart2_baud_clock_in;
    logic       serial2_data_in;
    logic       uart_baud_clock_in;
    logic       serial1_data_in;
    logic       serial0_clock_in;
    logic       serial0_data_in;
    logic [7:0] ad_in;
    logic       nmi_request;
    logic [5:0] ext_irq_request;
    logic [5:0] external_irq_inputs;
    logic       timer1_capture_trig;
    logic       timer1_count_clk;
    logic       rt_output_trig;
    logic       timer2_capture_trig;
    logic       timer2_clock_in;
    logic       timer2_cc_capture_trig;
    logic       timer0_capture_trig;
    logic       timer0_count_clk;
    logic       adc_trig;
  } periph_sense_s;

endpackage : pin_mux_pkg

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps

// Two-stage synchroniser plus a delayed copy for edge detection.
module pin_sync #(
  parameter int W = 8
) (
  // Clock and reset.
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // Raw pins and clean levels.
  input  wire logic [W-1:0] pin_raw,
  output logic      [W-1:0] pin_level,
  output logic      [W-1:0] pin_prev
);

  logic [W-1:0] meta_reg;

  // The first stage feeds only the second stage, so metastability never reaches logic.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg  <= '0;
      pin_level <= '0;
      pin_prev  <= '0;
    end
    else
    begin
      meta_reg  <= pin_raw;
      pin_level <= meta_reg;
      pin_prev  <= pin_level;
    end
  end

endmodule : pin_sync

// ==== rtl/port_pin_function_mux.sv ====
`timescale 1ns/1ps

// Operation
// - Port 1 bits 2-4 alternate only when selected.
// - Port 1 direction set per bit.
// - Each port 1 select bit switches one pin.
// - Port 1 alternates: serial2 clock, data in, out.
// - Port 2 is eight Schmitt-buffered inputs.
// - Port 2 bits 2-7 have switchable pull-ups.
// - Port 2 bit 5 drives serial1 clock when enabled.
// - Port 2 inputs feed interrupts and serial inputs.
// - Port 2 reads return pin levels always.
// - NMI edge polarity chosen by config A.
// - NMI request ignores maskable interrupt enable.
// - External interrupts fire on programmed edges.
// - External interrupt inputs also drive peripheral triggers.
// - Port 3 bidirectional with latch, direction, pull-ups.
// - Port 3 bits 2-3 may be open-drain.
// - Port 3 select bits pick serial or timer functions.
// - Port 3 reads return pin levels always.
// - Port 3 resets to inputs, outputs released.
// - Port 4 bidirectional with latch, direction, pull-ups.
// - Memory expansion turns port 4 into address/data.
// - Port 4 resets to inputs, outputs released.
// - Port 1 resets to inputs, outputs released.
module port_pin_function_mux
  import pin_mux_pkg::*;
(
  // Clock and reset.
  input  wire logic                sys_clk,
  input  wire logic                arst_n,
  // AXI4-Lite write channels.
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic [DATA_W/8-1:0] wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  // AXI4-Lite read channels.
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [DATA_W-1:0]        rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  // Port 1 pads.
  input  wire logic [PORT_W-1:0]   p1_in,
  output logic [PORT_W-1:0]        p1_out,
  output logic [PORT_W-1:0]        p1_oe_n,
  // Port 2 pads.
  input  wire logic [PORT_W-1:0]   p2_in,
  output logic [PORT_W-1:0]        p2_pullup_en,
  output logic                     p2_sck_out,
  output logic                     p2_sck_oe_n,
  // Port 3 pads.
  input  wire logic [PORT_W-1:0]   p3_in,
  output logic [PORT_W-1:0]        p3_out,
  output logic [PORT_W-1:0]        p3_oe_n,
  output logic [PORT_W-1:0]        p3_pullup_en,
  // Port 4 pads.
  input  wire logic [PORT_W-1:0]   p4_in,
  output logic [PORT_W-1:0]        p4_out,
  output logic [PORT_W-1:0]        p4_oe_n,
  output logic [PORT_W-1:0]        p4_pullup_en,
  // Peripheral side.
  input  wire periph_drive_s       periph_drive,
  output periph_sense_s            periph_sense
);

  // Software registers.
  logic [7:0] p1_latch_reg, p1_direction_reg, port1_function_select_reg;
  logic [7:0] p2_pull_reg;
  logic [7:0] p3_latch_reg, p3_direction_reg, port3_function_select_reg, p3_pull_reg, p3_od_reg;
  logic [7:0] p4_latch_reg, p4_direction_reg, p4_pull_reg;
  logic [7:0] memory_expansion_mode_reg, clocked_serial1_mode_reg;
  logic [7:0] ext_irq_edge_cfg_a_reg, ext_irq_edge_cfg_b_reg;

  // Bus state.
  logic              aw_full_reg, w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0]        w_data_reg;
  logic              w_lane0_reg;
  logic              aw_take, w_take, ar_take, do_write;
  logic [DATA_W-1:0] rdata_next;
  logic [1:0]        rresp_next, bresp_next;

  // Pin levels after synchronisation.
  logic [4*PORT_W-1:0] pins_level, pins_prev;
  logic [PORT_W-1:0]   p1_lvl, p2_lvl, p3_lvl, p4_lvl, p2_prv;

  // Pad drive next values.
  logic [PORT_W-1:0] p1_out_next, p1_drive, p3_out_next, p3_drive, p4_out_next, p4_drive;
  logic [IRQ_N-1:0]  irq_edge;
  logic [1:0]        irq_sel [IRQ_N];
  logic              nmi_edge;

  // All pads are resynchronised in one bank; Schmitt buffering sits in the pad cell.
  pin_sync #(
    .W (4*PORT_W)
  ) u_pin_sync (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .pin_raw   ({p4_in, p3_in, p2_in, p1_in}),
    .pin_level (pins_level),
    .pin_prev  (pins_prev)
  );

  assign {p4_lvl, p3_lvl, p2_lvl, p1_lvl} = pins_level;
  assign p2_prv = pins_prev[2*PORT_W-1:PORT_W];

  // Handshake terms; one write and one read are in flight at most.
  assign aw_take  = awvalid & awready;
  assign w_take   = wvalid & wready;
  assign ar_take  = arvalid & arready;
  assign do_write = aw_full_reg & w_full_reg & ~bvalid;

  // Write address and data are captured separately so either may come first.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= ZERO_RESET;
      w_lane0_reg <= 1'b0;
      awready     <= 1'b0;
      wready      <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= RESP_OKAY;
    end
    else
    begin
      aw_full_reg <= aw_take | (aw_full_reg & ~do_write);
      if (aw_take)
        aw_addr_reg <= awaddr;
      w_full_reg <= w_take | (w_full_reg & ~do_write);
      if (w_take)
      begin
        w_data_reg  <= wdata[7:0];
        w_lane0_reg <= wstrb[0];
      end
      awready <= ~aw_take & ~aw_full_reg & ~bvalid;
      wready  <= ~w_take & ~w_full_reg & ~bvalid;
      bvalid  <= do_write | (bvalid & ~bready);
      if (do_write)
        bresp <= bresp_next;
    end
  end

  // A write to an unmapped word is answered with an error and stores nothing.
  // The mapped words are contiguous and aligned, from the first offset up to the last.
  assign bresp_next = (aw_addr_reg[1:0] == 2'h0 && aw_addr_reg <= OFF_IRQ_CFG_B) ? RESP_OKAY : RESP_SLVERR;

  // Register writes; only byte lane 0 carries data, pin-level words are read-only.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      p1_direction_reg <= DIR_RESET;
      p3_direction_reg <= DIR_RESET;
      p4_direction_reg <= DIR_RESET;
      {p1_latch_reg, port1_function_select_reg, p2_pull_reg, p3_latch_reg, port3_function_select_reg, p3_pull_reg,
        p3_od_reg, p4_latch_reg, p4_pull_reg, memory_expansion_mode_reg, clocked_serial1_mode_reg,
        ext_irq_edge_cfg_a_reg, ext_irq_edge_cfg_b_reg} <= '0;
    end
    else if (do_write && w_lane0_reg)
    begin
      case (aw_addr_reg)
        OFF_P1_LATCH:  p1_latch_reg              <= w_data_reg;
        OFF_P1_DIR:    p1_direction_reg          <= w_data_reg;
        OFF_P1_FSEL:   port1_function_select_reg <= w_data_reg & P1_FSEL_MASK;
        OFF_P2_PULL:   p2_pull_reg               <= w_data_reg & P2_PULL_MASK;
        OFF_P3_LATCH:  p3_latch_reg              <= w_data_reg;
        OFF_P3_DIR:    p3_direction_reg          <= w_data_reg;
        OFF_P3_FSEL:   port3_function_select_reg <= w_data_reg;
        OFF_P3_PULL:   p3_pull_reg               <= w_data_reg;
        OFF_P3_OD:     p3_od_reg                 <= w_data_reg & P3_OD_MASK;
        OFF_P4_LATCH:  p4_latch_reg              <= w_data_reg;
        OFF_P4_DIR:    p4_direction_reg          <= w_data_reg;
        OFF_P4_PULL:   p4_pull_reg               <= w_data_reg;
        OFF_MEMX_MODE: memory_expansion_mode_reg <= w_data_reg;
        OFF_CSI1_MODE: clocked_serial1_mode_reg  <= w_data_reg;
        OFF_IRQ_CFG_A: ext_irq_edge_cfg_a_reg    <= w_data_reg;
        OFF_IRQ_CFG_B: ext_irq_edge_cfg_b_reg    <= w_data_reg;
        default:       p1_latch_reg              <= p1_latch_reg;
      endcase
    end
  end

  // Read decode; pin words show synchronised pad levels whatever the pin is doing.
  always_comb
  begin
    rdata_next = '0;
    rresp_next = RESP_OKAY;
    case (araddr)
      OFF_P1_LATCH:  rdata_next[7:0] = p1_latch_reg;
      OFF_P1_DIR:    rdata_next[7:0] = p1_direction_reg;
      OFF_P1_FSEL:   rdata_next[7:0] = port1_function_select_reg;
      OFF_P1_PINS:   rdata_next[7:0] = p1_lvl;
      OFF_P2_PULL:   rdata_next[7:0] = p2_pull_reg;
      OFF_P2_PINS:   rdata_next[7:0] = p2_lvl;
      OFF_P3_LATCH:  rdata_next[7:0] = p3_latch_reg;
      OFF_P3_DIR:    rdata_next[7:0] = p3_direction_reg;
      OFF_P3_FSEL:   rdata_next[7:0] = port3_function_select_reg;
      OFF_P3_PULL:   rdata_next[7:0] = p3_pull_reg;
      OFF_P3_OD:     rdata_next[7:0] = p3_od_reg;
      OFF_P3_PINS:   rdata_next[7:0] = p3_lvl;
      OFF_P4_LATCH:  rdata_next[7:0] = p4_latch_reg;
      OFF_P4_DIR:    rdata_next[7:0] = p4_direction_reg;
      OFF_P4_PULL:   rdata_next[7:0] = p4_pull_reg;
      OFF_P4_PINS:   rdata_next[7:0] = p4_lvl;
      OFF_MEMX_MODE: rdata_next[7:0] = memory_expansion_mode_reg;
      OFF_CSI1_MODE: rdata_next[7:0] = clocked_serial1_mode_reg;
      OFF_IRQ_CFG_A: rdata_next[7:0] = ext_irq_edge_cfg_a_reg;
      OFF_IRQ_CFG_B: rdata_next[7:0] = ext_irq_edge_cfg_b_reg;
      default:       rresp_next      = RESP_SLVERR;
    endcase
  end

  // Read channel; the word is sampled at address acceptance and held until taken.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end
    else
    begin
      arready <= ~ar_take & ~rvalid;
      rvalid  <= ar_take | (rvalid & ~rready);
      if (ar_take)
      begin
        rdata <= rdata_next;
        rresp <= rresp_next;
      end
    end
  end

  // Pad drive selection; an output alternate replaces both latch and direction.
  always_comb
  begin
    p1_out_next = p1_latch_reg;
    p1_drive    = ~p1_direction_reg;
    if (port1_function_select_reg[P1_SCK_BIT])
    begin
      p1_out_next[P1_SCK_BIT] = periph_drive.serial2_clock_out;
      p1_drive[P1_SCK_BIT]    = periph_drive.serial2_clock_oe;
    end
    if (port1_function_select_reg[P1_SIN_BIT])
      p1_drive[P1_SIN_BIT] = 1'b0;
    if (port1_function_select_reg[P1_SOUT_BIT])
    begin
      p1_out_next[P1_SOUT_BIT] = periph_drive.serial2_data_out;
      p1_drive[P1_SOUT_BIT]    = 1'b1;
    end
    p3_out_next = p3_latch_reg;
    p3_drive    = ~p3_direction_reg;
    for (int i = 0; i < PORT_W; i++)
    begin
      if (port3_function_select_reg[i])
      begin
        p3_drive[i] = 1'b1;
        if (i == P3_RX_BIT)
          p3_drive[i] = 1'b0;
        else if (i == P3_TX_BIT)
          p3_out_next[i] = periph_drive.serial1_data_out;
        else if (i == P3_SERIAL0_CLOCK_BIT)
        begin
          p3_out_next[i] = periph_drive.serial0_clock_out;
          p3_drive[i]    = periph_drive.serial0_clock_oe;
        end
        else if (i == P3_SO0_BIT)
          p3_out_next[i] = periph_drive.serial0_data_out;
        else
          p3_out_next[i] = periph_drive.timer_outputs[i-P3_TIMER_BASE];
      end
      // Open-drain pins only ever pull low; a high level is left to the external pull-up.
      if (p3_od_reg[i])
      begin
        p3_drive[i]    = p3_drive[i] & ~p3_out_next[i];
        p3_out_next[i] = 1'b0;
      end
    end
    p4_out_next = p4_latch_reg;
    p4_drive    = ~p4_direction_reg;
    if (memory_expansion_mode_reg[MEMX_EN_BIT])
    begin
      p4_out_next = periph_drive.ad_out;
      p4_drive    = {PORT_W{periph_drive.ad_oe}};
    end
  end

  // Pad outputs are registered, costing one cycle but keeping pads glitch-free.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {p1_out, p2_pullup_en, p3_out, p3_pullup_en, p4_out, p4_pullup_en, p2_sck_out} <= '0;
      {p1_oe_n, p3_oe_n, p4_oe_n, p2_sck_oe_n} <= '1;
    end
    else
    begin
      p1_out       <= p1_out_next;
      p1_oe_n      <= ~p1_drive;
      p2_pullup_en <= p2_pull_reg & P2_PULL_MASK;
      p2_sck_out   <= periph_drive.serial1_clock_out;
      p2_sck_oe_n  <= ~clocked_serial1_mode_reg[CSI1_CLKOUT_BIT];
      p3_out       <= p3_out_next;
      p3_oe_n      <= ~p3_drive;
      p3_pullup_en <= p3_pull_reg & ~p3_drive;
      p4_out       <= p4_out_next;
      p4_oe_n      <= ~p4_drive;
      p4_pullup_en <= p4_pull_reg & ~p4_drive;
    end
  end

  // Edge detection on clean levels; each external interrupt has its own rise and fall enables, NMI a single polarity bit.
  always_comb
  begin
    for (int n = 0; n < IRQ_N; n++)
    begin
      irq_sel[n] = (n < IRQ_PER_CFG) ? ext_irq_edge_cfg_a_reg[2*n+2 +: 2]
                                     : ext_irq_edge_cfg_b_reg[2*(n-IRQ_PER_CFG) +: 2];
      irq_edge[n] = (irq_sel[n][EDGE_RISE] & p2_lvl[n+P2_IRQ_BASE] & ~p2_prv[n+P2_IRQ_BASE])
                  | (irq_sel[n][EDGE_FALL] & ~p2_lvl[n+P2_IRQ_BASE] & p2_prv[n+P2_IRQ_BASE]);
    end
    nmi_edge = ext_irq_edge_cfg_a_reg[NMI_RISE_BIT] ? (p2_lvl[P2_NMI_BIT] & ~p2_prv[P2_NMI_BIT])
                                                     : (~p2_lvl[P2_NMI_BIT] & p2_prv[P2_NMI_BIT]);
  end

  // Peripheral-facing levels and one-cycle event pulses; NMI has no enable gate.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      periph_sense <= '0;
    else
    begin
      periph_sense.uart2_baud_clock_in    <= p1_lvl[P1_SCK_BIT];
      periph_sense.serial2_data_in        <= p1_lvl[P1_SIN_BIT];
      periph_sense.uart_baud_clock_in     <= p2_lvl[P2_SERIAL1_CLOCK_BIT];
      periph_sense.serial0_data_in        <= p2_lvl[P2_SI0_BIT];
      periph_sense.serial1_data_in        <= p3_lvl[P3_RX_BIT];
      periph_sense.serial0_clock_in       <= p3_lvl[P3_SERIAL0_CLOCK_BIT];
      periph_sense.ad_in                  <= p4_lvl;
      periph_sense.nmi_request            <= nmi_edge;
      periph_sense.ext_irq_request        <= irq_edge;
      periph_sense.external_irq_inputs    <= p2_lvl[P2_IRQ_BASE +: IRQ_N];
      periph_sense.timer1_capture_trig    <= p2_lvl[P2_IRQ_BASE];
      periph_sense.timer1_count_clk       <= p2_lvl[P2_IRQ_BASE];
      periph_sense.rt_output_trig         <= p2_lvl[P2_IRQ_BASE];
      periph_sense.timer2_capture_trig    <= p2_lvl[P2_IRQ_BASE+1];
      periph_sense.timer2_clock_in        <= p2_lvl[P2_IRQ_BASE+2];
      periph_sense.timer2_cc_capture_trig <= p2_lvl[P2_IRQ_BASE+2];
      periph_sense.timer0_capture_trig    <= p2_lvl[P2_IRQ_BASE+3];
      periph_sense.timer0_count_clk       <= p2_lvl[P2_IRQ_BASE+3];
      periph_sense.adc_trig               <= p2_lvl[P2_IRQ_BASE+5];
    end
  end

endmodule : port_pin_function_mux

// ==== bench/port_pin_function_mux_properties.sv ====
`timescale 1ns/1ps

// Pin-to-sense checks wait until the synchronisers hold only history from after reset.
module pin_mux_checker
  import pin_mux_pkg::*;
(
  // Clock and reset.
  input wire logic          sys_clk,
  input wire logic          arst_n,
  // Pads.
  input wire logic [7:0]    p2_in,
  input wire logic [7:0]    p1_oe_n,
  input wire logic [7:0]    p3_oe_n,
  input wire logic [7:0]    p4_oe_n,
  input wire logic [7:0]    p2_pullup_en,
  input wire logic          p2_sck_out,
  input wire logic          p2_sck_oe_n,
  // Bus and peripherals.
  input wire logic          awvalid,
  input wire logic          awready,
  input wire logic          wvalid,
  input wire logic          wready,
  input wire logic          bvalid,
  input wire periph_drive_s periph_drive,
  input wire periph_sense_s periph_sense
);
  logic [2:0] up_cnt;

  // Saturating count of edges since reset.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      up_cnt <= 3'h0;
    else if (up_cnt != 3'h7)
      up_cnt <= up_cnt + 3'h1;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  pads_released_a: assert property ($rose(arst_n) |-> &{p1_oe_n, p3_oe_n, p4_oe_n, p2_sck_oe_n})
    else $error("pad driven at release");
  p2_pull_low_a: assert property (p2_pullup_en[1:0] == 2'h0)
    else $error("low pull-up on");
  si0_level_a: assert property (up_cnt == 3'h7 |-> periph_sense.serial0_data_in == $past(p2_in[7], 3))
    else $error("serial level wrong");
  irq_trig_a: assert property (up_cnt == 3'h7 |->
    {periph_sense.external_irq_inputs, periph_sense.adc_trig} == {$past(p2_in[6:1], 3), $past(p2_in[6], 3)})
    else $error("trigger level wrong");
  nmi_edge_a: assert property (up_cnt == 3'h7 && periph_sense.nmi_request |->
    $past(p2_in[0], 3) != $past(p2_in[0], 4))
    else $error("stray nmi");
  irq_edge_a: assert property (up_cnt == 3'h7 |->
    (periph_sense.ext_irq_request & ~($past(p2_in[6:1], 3) ^ $past(p2_in[6:1], 4))) == 6'h0)
    else $error("stray irq");
  sck_drive_a: assert property (!p2_sck_oe_n |-> p2_sck_out == $past(periph_drive.serial1_clock_out))
    else $error("clock pin wrong");
  write_answer_a: assert property (awvalid && awready && wvalid && wready |=> !awready && !bvalid ##1 bvalid)
    else $error("write answer late");
endmodule : pin_mux_checker

bind port_pin_function_mux pin_mux_checker chk (.*);

// ==== bench/pad_board.sv ====
`timescale 1ns/1ps

// Board side of one pad group; a pin nobody holds wanders, so a stale level never passes.
module pad_board (
  // Clock.
  input wire logic       sys_clk,
  // Chip and board drive.
  input wire logic [7:0] out,
  input wire logic [7:0] oe_n,
  input wire logic [7:0] pull,
  input wire logic [7:0] drv,
  input wire logic [7:0] drv_en,
  // Resolved level.
  output logic     [7:0] level
);
  logic [7:0] wander = 8'h55;

  // Floating pins change every cycle.
  always @(posedge sys_clk)
    wander <= ~wander;

  // The chip wins where it drives.
  assign level = (~oe_n & out) | (oe_n & drv_en & drv) | (oe_n & ~drv_en & (pull | wander));
endmodule : pad_board

// ==== bench/port_pin_function_mux_bench.sv ====
`timescale 1ns/1ps

module port_pin_function_mux_bench
  import pin_mux_pkg::*;
;
  logic sys_clk = 1'h0, arst_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, d1 = 8'h0, d2 = 8'h0, d3 = 8'h0, e3 = 8'h0, d4 = 8'h0, e4 = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, p2_sck_out, p2_sck_oe_n;
  logic [1:0] bresp, rresp;
  logic [7:0] p1_in, p1_out, p1_oe_n, p2_in, p2_pullup_en, p3_in, p3_out, p3_oe_n, p3_pullup_en, p4_in, p4_out;
  logic [7:0] p4_oe_n, p4_pullup_en;
  periph_drive_s periph_drive = '0;
  periph_sense_s periph_sense;
  int fail_count = 0, n_compared = 0, cyc = 0;
  logic [23:0] tbl [6] = '{24'h050303, 24'h050000, 24'h004000, 24'h000040, 24'h000100, 24'h000001};

  // 50 MHz clock.
  initial
    forever #10 sys_clk = ~sys_clk;

  port_pin_function_mux uut (.sys_clk, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .p1_in, .p1_out, .p1_oe_n,
    .p2_in, .p2_pullup_en, .p2_sck_out, .p2_sck_oe_n, .p3_in, .p3_out, .p3_oe_n, .p3_pullup_en, .p4_in, .p4_out,
    .p4_oe_n, .p4_pullup_en, .periph_drive, .periph_sense);
  pad_board b1 (.sys_clk, .out(p1_out), .oe_n(p1_oe_n), .pull(8'h0), .drv(d1), .drv_en(8'h08), .level(p1_in));
  pad_board b2 (.sys_clk, .out({2'h0, p2_sck_out, 5'h0}), .oe_n({2'h3, p2_sck_oe_n, 5'h1f}), .pull(p2_pullup_en),
    .drv(d2), .drv_en(8'hff), .level(p2_in));
  pad_board b3 (.sys_clk, .out(p3_out), .oe_n(p3_oe_n), .pull(p3_pullup_en), .drv(d3), .drv_en(e3), .level(p3_in));
  pad_board b4 (.sys_clk, .out(p4_out), .oe_n(p4_oe_n), .pull(p4_pullup_en), .drv(d4), .drv_en(e4), .level(p4_in));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Both write channels are offered together; each is released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end
    while (!bvalid);
    bready <= 1'h0;
    @(negedge sys_clk); // Pads change at the answering edge; look once they have.
    chk("bresp", {30'h0, a == 8'hfc ? RESP_SLVERR : RESP_OKAY}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      if (arready)
        arvalid <= 1'h0;
    end
    while (!rvalid);
    rready <= 1'h0;
    chk("rdata", exp, rdata);
    chk("rresp", {30'h0, a == 8'hfc ? RESP_SLVERR : RESP_OKAY}, {30'h0, rresp});
  endtask : rd

  task automatic end_of_test;
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Sense paths need three edges; six leaves margin.
  task automatic settle;
    repeat (6) @(posedge sys_clk);
  endtask : settle

  task automatic port1_test;
    chk("reset_oe_n", 32'hffffff, {8'h0, p1_oe_n, p3_oe_n, p4_oe_n});
    rd(8'hfc, 32'h0);
    wr(8'hfc, 32'h5a);
    rd(OFF_P1_DIR, 32'hff);
    d1 <= 8'h08;
    wr(OFF_P1_LATCH, 32'ha5);
    wr(OFF_P1_DIR, 32'hf0);
    chk("p1_port", 32'hf005, {16'h0, p1_oe_n, p1_out & 8'h0f});
    periph_drive.serial2_clock_oe <= 1'h1;
    periph_drive.serial2_data_out <= 1'h1;
    wr(OFF_P1_DIR, 32'h0);
    wr(OFF_P1_FSEL, 32'hff);
    rd(OFF_P1_FSEL, 32'h1c);
    settle;
    chk("p1_alt", 32'h108b9, {15'h0, periph_sense.serial2_data_in, p1_oe_n, p1_out | p1_oe_n});
    wr(OFF_P1_FSEL, 32'h04);
    chk("p1_one", 32'h00a1, {16'h0, p1_oe_n, p1_out});
  endtask : port1_test

  task automatic port2_test;
    logic [6:0] seen;
    d2 <= 8'h5a;
    wr(OFF_P2_PULL, 32'hff);
    settle;
    rd(OFF_P2_PINS, 32'h5a);
    chk("p2_pullup_en", 32'hfc, {24'h0, p2_pullup_en});
    periph_drive.serial1_clock_out <= 1'h1;
    wr(OFF_CSI1_MODE, 32'h01);
    settle;
    rd(OFF_P2_PINS, 32'h7a);
    wr(OFF_CSI1_MODE, 32'h0);
    d2 <= 8'h0;
    wr(OFF_IRQ_CFG_B, 32'h20);
    settle;
    for (int i = 0; i < 6; i++)
    begin
      wr(OFF_IRQ_CFG_A, {24'h0, tbl[i][23:16]});
      seen = 7'h0;
      d2 <= tbl[i][15:8];
      repeat (6)
      begin
        @(posedge sys_clk);
        seen |= {periph_sense.ext_irq_request, periph_sense.nmi_request};
      end
      chk("irq_seen", {24'h0, tbl[i][7:0]}, {25'h0, seen});
    end
  endtask : port2_test

  task automatic port34_test;
    e3 <= 8'h05;
    d3 <= 8'h01;
    wr(OFF_P3_DIR, 32'h0);
    wr(OFF_P3_OD, 32'hff);
    rd(OFF_P3_OD, 32'h0c);
    wr(OFF_P3_LATCH, 32'h3c);
    chk("p3_od", 32'h0c3c, {16'h0, p3_oe_n, p3_out | p3_oe_n});
    periph_drive.timer_outputs <= 4'ha;
    periph_drive.serial1_data_out <= 1'h1;
    wr(OFF_P3_OD, 32'h0);
    wr(OFF_P3_FSEL, 32'hff);
    settle;
    chk("p3_alt", 32'h205a7, {14'h0, periph_sense.serial1_data_in, periph_sense.serial0_clock_in, p3_oe_n,
      p3_out | p3_oe_n});
    rd(OFF_P3_PINS, 32'ha3);
    wr(OFF_P4_DIR, 32'h0);
    wr(OFF_P4_LATCH, 32'h96);
    chk("p4_port", 32'h0096, {16'h0, p4_oe_n, p4_out});
    periph_drive.ad_out <= 8'h3c;
    periph_drive.ad_oe <= 1'h1;
    wr(OFF_MEMX_MODE, 32'h01);
    settle;
    chk("p4_ad_out", 32'h003c, {16'h0, p4_oe_n, p4_out});
    periph_drive.ad_oe <= 1'h0;
    e4 <= 8'hff;
    d4 <= 8'h5a;
    settle;
    chk("p4_ad_in", 32'hff5a, {16'h0, p4_oe_n, periph_sense.ad_in});
  endtask : port34_test

  // Main sequence after four cycles of reset.
  initial
  begin
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'h1;
    port1_test;
    port2_test;
    port34_test;
    end_of_test;
  end

  // Cuts a hang short.
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      end_of_test;
    end
  end
endmodule : port_pin_function_mux_bench
